// ### src/shrp_host_port.sv
/*
 * Host register port: two-wire slave on the system clock, four-wire slave on its own clock.
 * Assumes the register side answers a read one cycle after its request and holds it a cycle.
 */
`include "shrp_map.svh"
`default_nettype none
module shrp_host_port (
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Two-wire pins
	input wire logic i2c_scl_in,
	input wire logic i2c_sda_in,
	output logic i2c_sda_out,
	output logic i2c_sda_oe,
	input wire logic addr_select_high,
	input wire logic addr_select_low,
	// Four-wire pins
	input wire logic spi_clk,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	output logic spi_so,
	output logic spi_so_oe,
	// Register side
	output logic host_wr_valid,
	output logic [3:0] host_wr_index,
	output logic [7:0] host_wr_data,
	input wire logic tx_fifo_full,
	output logic host_rd_valid,
	output logic [3:0] host_rd_index,
	input wire logic [7:0] host_rd_data
);
	import shrp_pkg::*;

	function automatic shrp_sel_t sel_class(input logic [3:0] m);
		if (!m[0]) begin
			sel_class = SEL_VDD;
		end else if (!m[1]) begin
			sel_class = SEL_VSS;
		end else if (!m[2]) begin
			sel_class = SEL_SCL;
		end else begin
			sel_class = SEL_SDA;
		end
	endfunction : sel_class

	shrp_link_if lnk ();

	shrp_spi_link #(.BURST_MAX(`SHRP_BURST_MAX)) u_link (
		.spi_clk(spi_clk),
		.spi_cs_n(spi_cs_n),
		.spi_si(spi_si),
		.spi_so(spi_so),
		.spi_so_oe(spi_so_oe),
		.resetn(resetn),
		.lnk(lnk)
	);

	// **************************************
	// Pin and toggle synchronisers
	// **************************************
	logic [5:0] s1_q, s2_q;
	logic [3:0] p_q;
	logic scl, sda, scl_rise, scl_fall, start, stop, spi_wr_evt, spi_rd_evt;

	// Sampling at 8 ns leaves hundreds of samples per bit at 400 kbps.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s1_q <= `SHRP_SYNC_RST;
			s2_q <= `SHRP_SYNC_RST;
			p_q <= `SHRP_PREV_RST;
		end else if (clk_en) begin
			s1_q <= {lnk.rd_tgl, lnk.wr_tgl, addr_select_high, addr_select_low,
				i2c_sda_in, i2c_scl_in};
			s2_q <= s1_q;
			p_q <= {s2_q[5:4], s2_q[1:0]};
		end
	end

	assign scl = s2_q[0];
	assign sda = s2_q[1];
	assign scl_rise = scl & ~p_q[0];
	assign scl_fall = ~scl & p_q[0];
	assign start = scl & p_q[0] & p_q[1] & ~sda;
	assign stop = scl & p_q[0] & ~p_q[1] & sda;
	assign spi_wr_evt = s2_q[4] ^ p_q[2];
	assign spi_rd_evt = s2_q[5] ^ p_q[3];

	// **************************************
	// Address select classification
	// **************************************
	// A select pin tied to a bus line is only told apart once the bus has moved, which
	// always happens during the start and the first address bits.
	// Every start clears the marks, so the synchronisers' reset value cannot leave a stale one.
	logic [7:0] mis_q, mis_d;
	logic [6:0] my_addr;

	always_comb begin
		mis_d = (start ? 8'h00 : mis_q) | {s2_q[3] != sda, s2_q[3] != scl, s2_q[3], ~s2_q[3],
			s2_q[2] != sda, s2_q[2] != scl, s2_q[2], ~s2_q[2]};
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mis_q <= 8'h00;
		end else if (clk_en) begin
			mis_q <= mis_d;
		end
	end

	assign my_addr = `SHRP_I2C_BASE + {3'h0, sel_class(mis_q[7:4]), sel_class(mis_q[3:0])};

	// **************************************
	// Two-wire slave
	// **************************************
	shrp_i2c_st_t st_q, st_d, nx_q, nx_d;
	logic [3:0] bit_q, bit_d, idx_q, idx_d;
	logic [7:0] sh_q, sh_d, tx_q, tx_d;
	logic ok_q, ok_d, oe_q, oe_d, more_q, more_d, i2c_wr_go, i2c_rd_go;
	logic ld_q, lown_q;

	// The clock is left high after the last transaction, so idle needs no timeout.
	always_comb begin
		st_d = st_q;
		nx_d = nx_q;
		bit_d = bit_q;
		idx_d = idx_q;
		sh_d = sh_q;
		tx_d = tx_q;
		ok_d = ok_q;
		oe_d = oe_q;
		more_d = more_q;
		i2c_wr_go = 1'b0;
		i2c_rd_go = 1'b0;
		if (ld_q && !lown_q) begin
			tx_d = host_rd_data;
		end
		if (start) begin
			st_d = I2C_ADDR;
			bit_d = 4'h0;
			oe_d = 1'b0;
		end else if (stop) begin
			st_d = I2C_IDLE;
			oe_d = 1'b0;
		end else begin
			case (st_q)
				I2C_ADDR, I2C_SUB, I2C_WDAT: begin
					if (scl_rise && bit_q != 4'h8) begin
						sh_d = {sh_q[6:0], sda};
						bit_d = bit_q + 4'h1;
					end else if (scl_fall && bit_q == 4'h8) begin
						bit_d = 4'h0;
						st_d = I2C_ACK;
						oe_d = 1'b1;
						nx_d = I2C_WDAT;
						if (st_q == I2C_ADDR) begin
							if (sh_q[7:1] != my_addr) begin
								st_d = I2C_IDLE;
								oe_d = 1'b0;
							end else if (sh_q[0]) begin
								nx_d = I2C_RDAT;
								i2c_rd_go = ok_q;
								if (!ok_q) begin
									tx_d = 8'h00;
								end
							end else begin
								nx_d = I2C_SUB;
							end
						end else if (st_q == I2C_SUB) begin
							idx_d = sh_q[`SHRP_F_IDX];
							ok_d = (sh_q[`SHRP_F_CHAN] == `SHRP_CHAN_A);
						end else if (ok_q && idx_q == `SHRP_IDX_TXFIFO && tx_fifo_full) begin
							oe_d = 1'b0;
						end else begin
							i2c_wr_go = ok_q;
						end
					end
				end
				I2C_ACK: begin
					if (scl_fall) begin
						st_d = nx_q;
						bit_d = 4'h0;
						oe_d = (nx_q == I2C_RDAT) ? ~tx_q[7] : 1'b0;
					end
				end
				I2C_RDAT: begin
					if (scl_fall) begin
						if (bit_q == 4'h7) begin
							oe_d = 1'b0;
							st_d = I2C_RACK;
						end else begin
							tx_d = {tx_q[6:0], 1'b0};
							oe_d = ~tx_q[6];
							bit_d = bit_q + 4'h1;
						end
					end
				end
				I2C_RACK: begin
					if (scl_rise) begin
						more_d = ~sda;
						i2c_rd_go = ~sda & ok_q;
					end else if (scl_fall) begin
						st_d = more_q ? I2C_RDAT : I2C_IDLE;
						oe_d = more_q & ~tx_q[7];
						bit_d = 4'h0;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= I2C_IDLE;
			nx_q <= I2C_IDLE;
			bit_q <= 4'h0;
			idx_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			ok_q <= 1'b0;
			oe_q <= 1'b0;
			more_q <= 1'b0;
		end else if (clk_en) begin
			st_q <= st_d;
			nx_q <= nx_d;
			bit_q <= bit_d;
			idx_q <= idx_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			ok_q <= ok_d;
			oe_q <= oe_d;
			more_q <= more_d;
		end
	end

	assign i2c_sda_out = 1'b0;
	assign i2c_sda_oe = oe_q;

	// **************************************
	// Register side requests
	// **************************************
	// The two-wire slave wins a shared cycle; a four-wire event waits one cycle in a
	// pending flag, and a new event in the grant cycle keeps the flag set.
	logic wv_q, wv_d, rv_q, rv_d, wp_q, wp_d, rp_q, rp_d, rown_q, rown_d, ld_d, lown_d;
	logic [3:0] wi_q, wi_d, ri_q, ri_d;
	logic [7:0] wd_q, wd_d, rw_q, rw_d;

	always_comb begin
		wv_d = 1'b0;
		rv_d = 1'b0;
		wi_d = wi_q;
		wd_d = wd_q;
		ri_d = ri_q;
		rown_d = rown_q;
		wp_d = wp_q | spi_wr_evt;
		rp_d = rp_q | spi_rd_evt;
		ld_d = rv_q;
		lown_d = rown_q;
		rw_d = rw_q;
		if (i2c_wr_go) begin
			wv_d = 1'b1;
			wi_d = idx_q;
			wd_d = sh_q;
		end else if (wp_q) begin
			wv_d = 1'b1;
			wi_d = lnk.index;
			wd_d = lnk.wr_byte;
			wp_d = spi_wr_evt;
		end
		if (i2c_rd_go) begin
			rv_d = 1'b1;
			ri_d = idx_q;
			rown_d = 1'b0;
		end else if (rp_q) begin
			rv_d = 1'b1;
			ri_d = lnk.index;
			rown_d = 1'b1;
			rp_d = spi_rd_evt;
		end
		if (ld_q && lown_q) begin
			rw_d = host_rd_data;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wv_q <= 1'b0;
			rv_q <= 1'b0;
			wi_q <= 4'h0;
			wd_q <= 8'h00;
			ri_q <= 4'h0;
			rown_q <= 1'b0;
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			ld_q <= 1'b0;
			lown_q <= 1'b0;
			rw_q <= 8'h00;
		end else if (clk_en) begin
			wv_q <= wv_d;
			rv_q <= rv_d;
			wi_q <= wi_d;
			wd_q <= wd_d;
			ri_q <= ri_d;
			rown_q <= rown_d;
			wp_q <= wp_d;
			rp_q <= rp_d;
			ld_q <= ld_d;
			lown_q <= lown_d;
			rw_q <= rw_d;
		end
	end

	assign host_wr_valid = wv_q & clk_en;
	assign host_wr_index = wi_q;
	assign host_wr_data = wd_q;
	assign host_rd_valid = rv_q & clk_en;
	assign host_rd_index = ri_q;
	assign lnk.rd_word = rw_q;

	chk_addr_ack: assert property (@(posedge sys_clk) disable iff (!resetn)
		(clk_en && !start && !stop && st_q == I2C_ADDR && scl_fall && bit_q == 4'h8
		&& sh_q[7:1] == my_addr) |=> (i2c_sda_oe && st_q == I2C_ACK))
		else $error("own address not acknowledged");
	chk_addr_miss: assert property (@(posedge sys_clk) disable iff (!resetn)
		(clk_en && !start && !stop && st_q == I2C_ADDR && scl_fall && bit_q == 4'h8
		&& sh_q[7:1] != my_addr) |=> (!i2c_sda_oe && st_q == I2C_IDLE))
		else $error("foreign address answered");
	chk_full_nack: assert property (@(posedge sys_clk) disable iff (!resetn)
		(clk_en && !start && !stop && st_q == I2C_WDAT && scl_fall && bit_q == 4'h8 && ok_q
		&& idx_q == `SHRP_IDX_TXFIFO && tx_fifo_full) |=> (!i2c_sda_oe && !wv_q))
		else $error("full transmit FIFO write acknowledged");
	chk_sub_decode: assert property (@(posedge sys_clk) disable iff (!resetn)
		(clk_en && !start && !stop && st_q == I2C_SUB && scl_fall && bit_q == 4'h8)
		|=> (idx_q == $past(sh_q[6:3]) && ok_q == ($past(sh_q[2:1]) == `SHRP_CHAN_A)))
		else $error("sub-address decoded wrongly");
	chk_read_dir: assert property (@(posedge sys_clk) disable iff (!resetn)
		(clk_en && !start && !stop && st_q == I2C_ADDR && scl_fall && bit_q == 4'h8
		&& sh_q[7:1] == my_addr && sh_q[0] && ok_q) |=> (rv_q && ri_q == $past(idx_q)))
		else $error("read direction did not fetch");
	chk_ack_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
		(st_q == I2C_ACK && i2c_sda_oe && !scl_fall && !start && !stop) |=> i2c_sda_oe)
		else $error("acknowledge released early");
	chk_spi_write: assert property (@(posedge sys_clk) disable iff (!resetn)
		(spi_wr_evt && clk_en) ##1 clk_en [*3] |-> (wv_q || $past(wv_q)))
		else $error("four-wire write byte not issued");
	chk_spi_fetch: assert property (@(posedge sys_clk) disable iff (!resetn)
		(spi_rd_evt && clk_en) ##1 clk_en [*3] |-> (rv_q || $past(rv_q)))
		else $error("four-wire read byte not fetched");
endmodule : shrp_host_port
`default_nettype wire

// ### src/shrp_link_if.sv
/*
 * Carrier between the four-wire link logic and the core of the host port.
 * Assumes the link side drives toggles on the link clock and the core samples them.
 */
`default_nettype none
interface shrp_link_if;
	logic wr_tgl;
	logic [7:0] wr_byte;
	logic [3:0] index;
	logic rd_tgl;
	logic [7:0] rd_word;
	modport link (output wr_tgl, output wr_byte, output index, output rd_tgl, input rd_word);
	modport core (input wr_tgl, input wr_byte, input index, input rd_tgl, output rd_word);
endinterface : shrp_link_if
`default_nettype wire

// ### src/shrp_map.svh
/*
 * Constants of the serial host register port: address base, field positions, limits.
 * Assumes inclusion by bare name from the block's own files only.
 */
`ifndef SHRP_MAP_SVH
`define SHRP_MAP_SVH
// Seven-bit slave address base; the select pins add 0 to 15.
`define SHRP_I2C_BASE 7'h48
// Register index of the transmit FIFO.
`define SHRP_IDX_TXFIFO 4'h0
// The only valid channel code.
`define SHRP_CHAN_A 2'h0
// Most bytes taken or given in one four-wire sequence.
`define SHRP_BURST_MAX 64
// Command byte fields.
`define SHRP_F_RW 7
`define SHRP_F_IDX 6:3
`define SHRP_F_CHAN 2:1
// Reset level of the synchronised pins: clock and data idle high.
`define SHRP_SYNC_RST 6'h03
`define SHRP_PREV_RST 4'h3
`endif

// ### src/shrp_pkg.sv
/*
 * Types of the serial host register port.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package shrp_pkg;
	typedef enum logic [6:0] {
		I2C_IDLE = 7'h01,
		I2C_ADDR = 7'h02,
		I2C_SUB = 7'h04,
		I2C_WDAT = 7'h08,
		I2C_ACK = 7'h10,
		I2C_RDAT = 7'h20,
		I2C_RACK = 7'h40
	} shrp_i2c_st_t;
	typedef enum logic [1:0] {
		SEL_VDD = 2'h0,
		SEL_VSS = 2'h1,
		SEL_SCL = 2'h2,
		SEL_SDA = 2'h3
	} shrp_sel_t;
endpackage : shrp_pkg
`default_nettype wire

// ### src/shrp_spi_link.sv
/*
 * Four-wire slave shifter running on the link clock.
 * Assumes the core fetches read bytes within half a link clock period of a read toggle.
 */
`include "shrp_map.svh"
`default_nettype none
module shrp_spi_link #(
	parameter int BURST_MAX = `SHRP_BURST_MAX
) (
	// Link pins
	input wire logic spi_clk,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	output logic spi_so,
	output logic spi_so_oe,
	// Reset
	input wire logic resetn,
	// Core side
	shrp_link_if.link lnk
);
	import shrp_pkg::*;
	localparam int CW = $clog2(BURST_MAX + 1);
	localparam logic [CW-1:0] CMAX = CW'(BURST_MAX);
	localparam logic [CW-1:0] CMAX1 = CW'(BURST_MAX - 1);
	logic rst_l_n;
	logic [2:0] bit_q, bit_d;
	logic [6:0] sh_q, sh_d;
	logic cmd_q, cmd_d, rd_q, rd_d, ok_q, ok_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic wt_q, wt_d, rt_q, rt_d;
	logic [7:0] wb_q, wb_d, out_q, out_d, byte_in;
	logic [3:0] idx_q, idx_d;

	// A raised select holds the frame state cleared, so every frame starts afresh.
	assign rst_l_n = resetn & ~spi_cs_n;

	// **************************************
	// Sampling on rising edges
	// **************************************
	always_comb begin
		byte_in = {sh_q, spi_si};
		bit_d = bit_q + 3'h1;
		sh_d = byte_in[6:0];
		cmd_d = cmd_q;
		rd_d = rd_q;
		ok_d = ok_q;
		cnt_d = cnt_q;
		wt_d = wt_q;
		rt_d = rt_q;
		wb_d = wb_q;
		idx_d = idx_q;
		if (bit_q == 3'h7) begin
			if (!cmd_q) begin
				cmd_d = 1'b1;
				rd_d = byte_in[`SHRP_F_RW];
				idx_d = byte_in[`SHRP_F_IDX];
				ok_d = (byte_in[`SHRP_F_CHAN] == `SHRP_CHAN_A);
				if (byte_in[`SHRP_F_RW] && byte_in[`SHRP_F_CHAN] == `SHRP_CHAN_A) begin
					rt_d = ~rt_q;
				end
			end else if (ok_q && cnt_q < CMAX) begin
				cnt_d = cnt_q + 1'b1;
				if (!rd_q) begin
					wb_d = byte_in;
					wt_d = ~wt_q;
				end else if (cnt_q < CMAX1) begin
					rt_d = ~rt_q;
				end
			end
		end
	end

	always_ff @(posedge spi_clk or negedge rst_l_n) begin
		if (!rst_l_n) begin
			bit_q <= 3'h0;
			sh_q <= 7'h00;
			cmd_q <= 1'b0;
			rd_q <= 1'b0;
			ok_q <= 1'b0;
			cnt_q <= '0;
		end else begin
			bit_q <= bit_d;
			sh_q <= sh_d;
			cmd_q <= cmd_d;
			rd_q <= rd_d;
			ok_q <= ok_d;
			cnt_q <= cnt_d;
		end
	end

	// Toggles and handed-over words survive the select, or the core would see false events.
	always_ff @(posedge spi_clk or negedge resetn) begin
		if (!resetn) begin
			wt_q <= 1'b0;
			rt_q <= 1'b0;
			wb_q <= 8'h00;
			idx_q <= 4'h0;
		end else begin
			wt_q <= wt_d;
			rt_q <= rt_d;
			wb_q <= wb_d;
			idx_q <= idx_d;
		end
	end

	// **************************************
	// Driving on falling edges
	// **************************************
	always_comb begin
		out_d = {out_q[6:0], 1'b0};
		if (bit_q == 3'h0 && cmd_q && rd_q) begin
			out_d = (ok_q && cnt_q < CMAX) ? lnk.rd_word : 8'h00;
		end
	end

	always_ff @(negedge spi_clk or negedge rst_l_n) begin
		if (!rst_l_n) begin
			out_q <= 8'h00;
		end else begin
			out_q <= out_d;
		end
	end

	assign spi_so = out_q[7];
	assign spi_so_oe = ~spi_cs_n;
	assign lnk.wr_tgl = wt_q;
	assign lnk.rd_tgl = rt_q;
	assign lnk.wr_byte = wb_q;
	assign lnk.index = idx_q;

	chk_burst_cap: assert property (@(posedge spi_clk) disable iff (!rst_l_n)
		(bit_q == 3'h7 && cmd_q && cnt_q == CMAX) |=> (lnk.wr_tgl == $past(lnk.wr_tgl)
		&& lnk.rd_tgl == $past(lnk.rd_tgl)))
		else $error("byte beyond burst limit handed over");
	chk_cmd_decode: assert property (@(posedge spi_clk) disable iff (!rst_l_n)
		(bit_q == 3'h7 && !cmd_q) |=> (cmd_q && rd_q == $past(sh_q[6])))
		else $error("command byte direction not taken");
	chk_wr_toggle: assert property (@(posedge spi_clk) disable iff (!rst_l_n)
		(bit_q == 3'h7 && cmd_q && ok_q && !rd_q && cnt_q < CMAX) |=> (lnk.wr_tgl != $past(lnk.wr_tgl)))
		else $error("write byte not handed over");
	chk_msb_first: assert property (@(negedge spi_clk) disable iff (!rst_l_n)
		(bit_q == 3'h0 && cmd_q && rd_q && ok_q && cnt_q < CMAX) |=> spi_so == $past(lnk.rd_word[7]))
		else $error("read byte not started with its top bit");
endmodule : shrp_spi_link
`default_nettype wire

// ### verification/shrp_host_master.sv
/*
 * Host master model: two-wire master at just under 400 kbps and four-wire mode 0 master.
 * Assumes the bench resolves the open-drain data wire and calls one task at a time.
 */
`default_nettype none
module shrp_host_master (
	// Pacing clock
	input wire logic sys_clk,
	// Two-wire pins
	output logic scl,
	output logic sda_low,
	input wire logic sda,
	// Four-wire pins
	output logic spi_clk,
	output logic spi_cs_n,
	output logic spi_si,
	input wire logic spi_so
);
	timeunit 1ns;
	timeprecision 1ps;
	// A quarter bit of 79 cycles keeps the rate just below the fast-mode ceiling.
	localparam int QUARTER = 79;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		spi_clk = 1'b0;
		spi_cs_n = 1'b1;
		spi_si = 1'b0;
	end
	task automatic tick();
		repeat (QUARTER) @(negedge sys_clk);
	endtask : tick
	task automatic bit_io(input logic b, output logic seen);
		sda_low = ~b;
		tick();
		scl = 1'b1;
		tick();
		seen = sda;
		tick();
		scl = 1'b0;
		tick();
	endtask : bit_io
	task automatic i2c_start();
		sda_low = 1'b0;
		tick();
		scl = 1'b1;
		tick();
		sda_low = 1'b1;
		tick();
		scl = 1'b0;
		tick();
	endtask : i2c_start
	task automatic i2c_stop();
		sda_low = 1'b1;
		tick();
		scl = 1'b1;
		tick();
		sda_low = 1'b0;
		tick();
	endtask : i2c_stop
	task automatic i2c_wr(input logic [7:0] b, output logic acked);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
		end
		bit_io(1'b1, s);
		acked = ~s;
	endtask : i2c_wr
	task automatic i2c_rd(input logic more, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, b[i]);
		end
		bit_io(~more, s);
	endtask : i2c_rd
	task automatic spi_open();
		spi_cs_n = 1'b0;
		#53;
	endtask : spi_open
	task automatic spi_close();
		#80;
		spi_cs_n = 1'b1;
		#300;
	endtask : spi_close
	task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			spi_si = tx[i];
			#80;
			spi_clk = 1'b1;
			rx[i] = spi_so;
			#80;
			spi_clk = 1'b0;
		end
	endtask : spi_byte
endmodule : shrp_host_master
`default_nettype wire

// ### verification/test_serial_host_register_port.sv
/*
 * Self-checking bench of the host register port with a host master model and a register side.
 * Assumes the register side answers reads one cycle after the request.
 */
`default_nettype none
module test_serial_host_register_port;
	import shrp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic tx_fifo_full = 1'b0;
	logic [7:0] host_rd_data = 8'h00;
	shrp_sel_t sel_h = SEL_VDD;
	shrp_sel_t sel_l = SEL_VDD;
	logic scl, sda_low, sda, sel_hi_pin, sel_lo_pin, spi_clk, spi_cs_n, spi_si;
	logic i2c_sda_out, i2c_sda_oe, spi_so, spi_so_oe, host_wr_valid, host_rd_valid;
	logic [3:0] host_wr_index, host_rd_index;
	logic [7:0] host_wr_data, b;
	logic [11:0] wr_log[$];
	int rd_count = 0;
	int num_errors = 0;
	int comparisons = 0;
	int n0;
	always #4 sys_clk = ~sys_clk;
	// Open drain with pull-up: the wire is low if any party pulls.
	assign sda = (i2c_sda_oe ? i2c_sda_out : 1'b1) & ~sda_low;
	function automatic logic pin_of(input shrp_sel_t s, input logic c, input logic d);
		return (s == SEL_VDD) ? 1'b1 : (s == SEL_VSS) ? 1'b0 : (s == SEL_SCL) ? c : d;
	endfunction : pin_of
	assign sel_hi_pin = pin_of(sel_h, scl, sda);
	assign sel_lo_pin = pin_of(sel_l, scl, sda);
	shrp_host_port i_shrp_host_port (.sys_clk(sys_clk), .resetn(resetn), .clk_en(1'b1),
		.i2c_scl_in(scl), .i2c_sda_in(sda), .i2c_sda_out(i2c_sda_out), .i2c_sda_oe(i2c_sda_oe),
		.addr_select_high(sel_hi_pin), .addr_select_low(sel_lo_pin), .spi_clk(spi_clk),
		.spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe),
		.host_wr_valid(host_wr_valid), .host_wr_index(host_wr_index),
		.host_wr_data(host_wr_data), .tx_fifo_full(tx_fifo_full),
		.host_rd_valid(host_rd_valid), .host_rd_index(host_rd_index),
		.host_rd_data(host_rd_data));
	shrp_host_master i_shrp_host_master (.sys_clk(sys_clk), .scl(scl), .sda_low(sda_low),
		.sda(sda), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so));
	// Register side: a read returns the index and its inverse, so bit order shows.
	always @(negedge sys_clk) begin
		if (host_rd_valid === 1'b1) begin
			host_rd_data <= {host_rd_index, ~host_rd_index};
			rd_count <= rd_count + 1;
		end
		if (host_wr_valid === 1'b1) begin
			wr_log.push_back({host_wr_index, host_wr_data});
		end
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check
	task automatic put(input logic [7:0] d, input logic exp_ack);
		logic s;
		i_shrp_host_master.i2c_wr(d, s);
		check("acknowledge", s, exp_ack);
	endtask : put
	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_address_map();
		// Repeated starts between probes keep the run short.
		for (int i = 0; i < 16; i++) begin
			sel_h = shrp_sel_t'(i[3:2]);
			sel_l = shrp_sel_t'(i[1:0]);
			i_shrp_host_master.i2c_start();
			put(8'h90 + 8'(2 * i), 1'b1);
		end
		sel_h = SEL_VDD;
		sel_l = SEL_VDD;
		i_shrp_host_master.i2c_start();
		put(8'h92, 1'b0);
		i_shrp_host_master.i2c_stop();
		check("probe writes", wr_log.size(), 0);
		$display("address map test done");
	endtask : t_address_map
	task automatic t_two_wire_write();
		i_shrp_host_master.i2c_start();
		put(8'h90, 1'b1);
		put(8'h00, 1'b1);
		put(8'hC3, 1'b1);
		i_shrp_host_master.i2c_start();
		put(8'h90, 1'b1);
		put(8'h2A, 1'b1);
		put(8'h11, 1'b1);
		i_shrp_host_master.i2c_stop();
		check("write count", wr_log.size(), 1);
		check("write word", wr_log[0], 12'h0C3);
		tx_fifo_full = 1'b1;
		i_shrp_host_master.i2c_start();
		put(8'h90, 1'b1);
		put(8'h00, 1'b1);
		put(8'h77, 1'b0);
		i_shrp_host_master.i2c_stop();
		tx_fifo_full = 1'b0;
		check("write count when full", wr_log.size(), 1);
		wr_log.delete();
		$display("two-wire write test done");
	endtask : t_two_wire_write
	task automatic t_two_wire_read();
		n0 = rd_count;
		i_shrp_host_master.i2c_start();
		put(8'h90, 1'b1);
		put(8'h38, 1'b1);
		i_shrp_host_master.i2c_start();
		put(8'h91, 1'b1);
		i_shrp_host_master.i2c_rd(1'b1, b);
		check("two-wire read", b, 8'h78);
		i_shrp_host_master.i2c_rd(1'b0, b);
		check("two-wire read", b, 8'h78);
		i_shrp_host_master.i2c_stop();
		check("two-wire requests", rd_count - n0, 2);
		check("writes in read", wr_log.size(), 0);
		$display("two-wire read test done");
	endtask : t_two_wire_read
	task automatic t_four_wire_read();
		n0 = rd_count;
		i_shrp_host_master.spi_open();
		i_shrp_host_master.spi_byte(8'hB0, b);
		check("command echo", b, 8'h00);
		check("out enable", spi_so_oe, 1'b1);
		for (int i = 0; i < 2; i++) begin
			i_shrp_host_master.spi_byte(8'hFF, b);
			check("four-wire read", b, 8'h69);
		end
		i_shrp_host_master.spi_close();
		check("four-wire requests", rd_count - n0, 3);
		check("out enable idle", spi_so_oe, 1'b0);
		n0 = rd_count;
		i_shrp_host_master.spi_open();
		i_shrp_host_master.spi_byte(8'hB2, b);
		i_shrp_host_master.spi_byte(8'hFF, b);
		i_shrp_host_master.spi_close();
		check("bad channel read", b, 8'h00);
		check("bad channel requests", rd_count - n0, 0);
		$display("four-wire read test done");
	endtask : t_four_wire_read
	task automatic t_four_wire_write();
		i_shrp_host_master.spi_open();
		i_shrp_host_master.spi_byte(8'h08, b);
		for (int i = 0; i < 65; i++) begin
			i_shrp_host_master.spi_byte(8'(i), b);
		end
		i_shrp_host_master.spi_close();
		check("burst length", wr_log.size(), 64);
		check("first burst word", wr_log[0], 12'h100);
		check("last burst word", wr_log[63], 12'h13F);
		$display("four-wire write test done");
	endtask : t_four_wire_write
	initial begin
		repeat (3) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (3) @(negedge sys_clk);
		t_address_map();
		t_two_wire_write();
		t_two_wire_read();
		t_four_wire_read();
		t_four_wire_write();
		conclude();
	end
	// The tests need about 0.9 ms; a tight limit ends a hung run soon.
	initial begin
		#1_000_000;
		num_errors++;
		$display("watchdog expired");
		conclude();
	end
endmodule : test_serial_host_register_port
`default_nettype wire
